// ### common/countdown_defs.svh
/*
  Constants for the pedestrian clearance countdown block.
  Assumes a 50 MHz core clock and millisecond ticks made from it.
*/
`ifndef COUNTDOWN_DEFS_SVH
`define COUNTDOWN_DEFS_SVH

// clock and tick periods
`define CLK_PERIOD_NS   20
`define MS_PERIOD_NS    1000000
// millisecond thresholds (10-bit ms counter in the timer, 11-bit lamp ms counters)
`define MS_PER_SEC      10'h3E8
`define HALF_SEC_MS     10'h1F4
`define STEADY_HALT_MS  11'h4B0
`define DARK_LAMPS_MS   11'h4B0
`define POWER_LOSS_MS   11'h5DC
`define MS_CNT_MAX      11'h7FF
// widths and display limits
`define SEC_W           7
`define SEG_W           7
`define MAX_SHOWN       7'h63
`endif

// ### common/cd_pkg.sv
/*
  Types shared by the countdown modules.
  Assumes countdown_defs.svh is on the include path.
*/
`include "countdown_defs.svh"
`default_nettype none
package cd_pkg;
  typedef logic [`SEC_W-1:0] sec_t;
  typedef logic [`SEG_W-1:0] seg_t;
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_WALK  = 2'b01,
    PH_CLEAR = 2'b10
  } phase_t;
endpackage
`default_nettype wire

// ### common/sec_timer_if.sv
/*
  Carrier between the countdown core and its seconds timer.
  Assumes both ends sit on the same core clock.
*/
`default_nettype none
interface sec_timer_if;
  logic         restart;
  logic         ms_tick;
  cd_pkg::sec_t elapsed;
  logic         past_half;
  modport timer (input restart, output ms_tick, elapsed, past_half);
  modport user  (output restart, input ms_tick, elapsed, past_half);
endinterface
`default_nettype wire

// ### core/sec_timer.sv
/*
  Free-running millisecond tick and restartable seconds counter.
  Assumes a synchronous active-high reset on the core clock.
*/
`include "countdown_defs.svh"
`default_nettype none
module sec_timer #(
  parameter int MS_CYCLES = `MS_PERIOD_NS / `CLK_PERIOD_NS
) (
  input  wire logic    core_clk_i,
  input  wire logic    rst_i,
  sec_timer_if.timer   tmr
);
  import cd_pkg::*;
  localparam int PW = $clog2(MS_CYCLES);

  if (MS_CYCLES < 2) begin : g_chk
    $error("MS_CYCLES must be at least 2");
  end

  logic [PW-1:0] pre_reg;
  logic [9:0]    ms_reg;
  sec_t          sec_reg;
  logic          pre_end;
  logic          ms_end;

  assign pre_end = (pre_reg == PW'(MS_CYCLES - 1));
  assign ms_end  = (ms_reg == (`MS_PER_SEC - 10'h001));

  always_ff @(posedge core_clk_i) begin
    if (rst_i || pre_end) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + PW'(1);
    end
  end

  // whole-second count from the last restart
  always_ff @(posedge core_clk_i) begin
    if (rst_i || tmr.restart) begin
      ms_reg  <= 10'h000;
      sec_reg <= '0;
    end else if (pre_end) begin
      ms_reg <= ms_end ? 10'h000 : ms_reg + 10'h001;
      if (ms_end && sec_reg != '1) begin
        sec_reg <= sec_reg + sec_t'(1);
      end
    end
  end

  assign tmr.ms_tick   = pre_end;
  assign tmr.elapsed   = sec_reg;
  assign tmr.past_half = (ms_reg >= `HALF_SEC_MS);
endmodule // sec_timer
`default_nettype wire

// ### core/seg7_pair.sv
/*
  Two-digit decimal to seven-segment decoder, segments a..g in bits 0..6.
  Assumes value below 100; the caller registers the outputs.
*/
`default_nettype none
module seg7_pair (
  input  wire logic         blank_i,
  input  wire cd_pkg::sec_t value_i,
  output var  cd_pkg::seg_t seg_o [2]
);
  import cd_pkg::*;
  logic [3:0] dig [2];

  assign dig[0] = 4'(value_i % 7'h0A);
  assign dig[1] = 4'(value_i / 7'h0A);

  for (genvar g = 0; g < 2; g++) begin : g_dig
    seg_t pat;
    always_comb begin
      case (dig[g])
        4'h0: pat = 7'h3F;
        4'h1: pat = 7'h06;
        4'h2: pat = 7'h5B;
        4'h3: pat = 7'h4F;
        4'h4: pat = 7'h66;
        4'h5: pat = 7'h6D;
        4'h6: pat = 7'h7D;
        4'h7: pat = 7'h07;
        4'h8: pat = 7'h7F;
        4'h9: pat = 7'h6F;
        default: pat = 7'h00;
      endcase
    end
    // leading zero of the tens digit stays dark
    assign seg_o[g] = (blank_i || (g == 1 && dig[1] == 4'h0)) ? '0 : pat;
  end
endmodule // seg7_pair
`default_nettype wire

// ### core/ped_countdown.sv
/*
  Pedestrian clearance countdown: watches the walk and halt lamp drives,
  learns the clearance interval and shows the remaining seconds.
  Assumes lamp and supply inputs are asynchronous levels from outside.
*/
`include "countdown_defs.svh"
`default_nettype none
module ped_countdown #(
  parameter int MS_CYCLES = `MS_PERIOD_NS / `CLK_PERIOD_NS
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         walk_lamp_i,
  input  wire logic         halt_lamp_i,
  input  wire logic         supply_good_i,
  output var  cd_pkg::seg_t seg_ones_o,
  output var  cd_pkg::seg_t seg_tens_o,
  output var  logic         display_on_o
);
  import cd_pkg::*;

  if (MS_CYCLES < 2) begin : g_chk
    $error("MS_CYCLES must be at least 2");
  end

  // ==========================================================
  // input synchronisers
  // ==========================================================
  localparam int NIN = 3;
  logic [NIN-1:0] pin_vec;
  logic [NIN-1:0] filt;

  assign pin_vec = {supply_good_i, halt_lamp_i, walk_lamp_i};

  for (genvar i = 0; i < NIN; i++) begin : g_sync
    logic [2:0] sh_reg;
    logic       lvl_reg;
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        sh_reg <= 3'h0;
      end else begin
        sh_reg <= {sh_reg[1:0], pin_vec[i]};
      end
    end
    // accept a change once stages two and three agree
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        lvl_reg <= 1'b0;
      end else if (sh_reg[1] == sh_reg[2]) begin
        lvl_reg <= sh_reg[2];
      end
    end
    assign filt[i] = lvl_reg;
  end

  logic walk_on;
  logic halt_on;
  logic supply_ok;
  assign walk_on   = filt[0];
  assign halt_on   = filt[1];
  assign supply_ok = filt[2];

  // ==========================================================
  // seconds timer
  // ==========================================================
  sec_timer_if tmr_if ();

  sec_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tmr (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tmr        (tmr_if.timer)
  );

  // ==========================================================
  // lamp state classification
  // ==========================================================
  function automatic logic [10:0] ms_run(
    input logic [10:0] c,
    input logic        on,
    input logic        tick
  );
    ms_run = !on ? 11'h000 : (tick && c != `MS_CNT_MAX) ? c + 11'h001 : c;
  endfunction

  logic [10:0] halt_ms_reg;
  logic [10:0] dark_ms_reg;
  logic [10:0] loss_ms_reg;
  logic        halt_q_reg;
  logic        walk_q_reg;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      halt_ms_reg <= 11'h000;
      dark_ms_reg <= 11'h000;
      loss_ms_reg <= 11'h000;
    end else begin
      halt_ms_reg <= ms_run(halt_ms_reg, halt_on, tmr_if.ms_tick);
      dark_ms_reg <= ms_run(dark_ms_reg, !halt_on && !walk_on, tmr_if.ms_tick);
      loss_ms_reg <= ms_run(loss_ms_reg, !supply_ok, tmr_if.ms_tick);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      halt_q_reg <= 1'b0;
      walk_q_reg <= 1'b0;
    end else begin
      halt_q_reg <= halt_on;
      walk_q_reg <= walk_on;
    end
  end

  logic halt_rise;
  logic walk_rise;
  logic steady_halt;
  logic lamps_dark;
  logic power_lost;
  sec_t meas;

  assign halt_rise   = halt_on && !halt_q_reg;
  assign walk_rise   = walk_on && !walk_q_reg;
  // halt lit longer than any flash on-time means steady
  assign steady_halt = (halt_ms_reg >= `STEADY_HALT_MS);
  assign lamps_dark  = (dark_ms_reg >= `DARK_LAMPS_MS);
  assign power_lost  = (loss_ms_reg > `POWER_LOSS_MS);
  // elapsed time rounded to whole seconds
  assign meas        = tmr_if.elapsed + sec_t'(tmr_if.past_half);

  // ==========================================================
  // cycle sequencing and learning
  // ==========================================================
  phase_t phase_reg;
  phase_t phase_next;
  logic   learn_reg;
  logic   learn_next;
  logic   full_reg;
  logic   full_next;
  logic   preempt_reg;
  logic   preempt_next;
  sec_t   clear_len_reg;
  sec_t   clear_len_next;
  sec_t   walk_len_reg;
  sec_t   walk_len_next;
  sec_t   walk_cap_reg;
  sec_t   walk_cap_next;
  sec_t   rise_cap_reg;
  sec_t   rise_cap_next;
  sec_t   end_len;
  logic   restart;
  logic   long_clear;

  // steady end uses the moment the halt lamp last came on
  assign end_len = steady_halt ? rise_cap_reg : meas;
  // flashing still going past the learned length; a lit halt may be the steady one
  assign long_clear = (halt_rise && meas > clear_len_reg) ||
                      (!halt_on && tmr_if.elapsed > clear_len_reg);

  always_comb begin
    phase_next     = phase_reg;
    learn_next     = learn_reg;
    full_next      = full_reg;
    preempt_next   = preempt_reg;
    clear_len_next = clear_len_reg;
    walk_len_next  = walk_len_reg;
    walk_cap_next  = walk_cap_reg;
    rise_cap_next  = rise_cap_reg;
    restart        = 1'b0;
    case (phase_reg)
      PH_IDLE: begin
        if (walk_rise) begin
          phase_next = PH_WALK;
          restart    = 1'b1;
          full_next  = 1'b1;
        end
      end
      PH_WALK: begin
        if (lamps_dark) begin
          phase_next = PH_IDLE;
          full_next  = 1'b0;
        end else if (halt_rise && !walk_on) begin
          phase_next    = PH_CLEAR;
          restart       = 1'b1;
          walk_cap_next = meas;
          rise_cap_next = '0;
          // walk shorter than learned means the controller preempted
          preempt_next  = !learn_reg && (meas < walk_len_reg);
        end
      end
      PH_CLEAR: begin
        if (halt_rise) begin
          rise_cap_next = meas;
        end
        if (lamps_dark) begin
          phase_next = PH_IDLE;
          full_next  = 1'b0;
        end else if (steady_halt || walk_rise) begin
          if (learn_reg && full_reg) begin
            clear_len_next = end_len;
            walk_len_next  = walk_cap_reg;
            learn_next     = 1'b0;
          end else if (!learn_reg && !preempt_reg && end_len != clear_len_reg) begin
            learn_next = 1'b1;
          end
          // walk returning without steady halt opens the next cycle
          phase_next = walk_rise ? PH_WALK : PH_IDLE;
          restart    = walk_rise;
          full_next  = walk_rise;
        end else if (!learn_reg && !preempt_reg && long_clear) begin
          learn_next = 1'b1;
          full_next  = 1'b0;
        end
      end
      default: begin
        phase_next = PH_IDLE;
      end
    endcase
    if (power_lost) begin
      phase_next = PH_IDLE;
      learn_next = 1'b1;
      full_next  = 1'b0;
    end
  end

  assign tmr_if.restart = restart;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      phase_reg   <= PH_IDLE;
      learn_reg   <= 1'b1;
      full_reg    <= 1'b0;
      preempt_reg <= 1'b0;
    end else begin
      phase_reg   <= phase_next;
      learn_reg   <= learn_next;
      full_reg    <= full_next;
      preempt_reg <= preempt_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      clear_len_reg <= '0;
      walk_len_reg  <= '0;
      walk_cap_reg  <= '0;
      rise_cap_reg  <= '0;
    end else begin
      clear_len_reg <= clear_len_next;
      walk_len_reg  <= walk_len_next;
      walk_cap_reg  <= walk_cap_next;
      rise_cap_reg  <= rise_cap_next;
    end
  end

  // ==========================================================
  // display
  // ==========================================================
  logic show;
  sec_t remain;
  sec_t shown;
  seg_t seg_pat [2];

  // one fixed countdown behaviour, no mode inputs exist
  assign show   = (phase_reg == PH_CLEAR) && !learn_reg;
  assign remain = (clear_len_reg > tmr_if.elapsed) ? clear_len_reg - tmr_if.elapsed : '0;
  assign shown  = !show ? '0 : (remain > `MAX_SHOWN) ? `MAX_SHOWN : remain;

  seg7_pair u_seg (
    .blank_i (!show),
    .value_i (shown),
    .seg_o   (seg_pat)
  );

  // each segment bit drives both emitter rows of that segment
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      seg_ones_o   <= '0;
      seg_tens_o   <= '0;
      display_on_o <= 1'b0;
    end else begin
      seg_ones_o   <= seg_pat[0];
      seg_tens_o   <= seg_pat[1];
      display_on_o <= show;
    end
  end
endmodule // ped_countdown
`default_nettype wire

// ### testbench/ped_countdown_props.sv
/*
  Port checker for the pedestrian clearance countdown.
  Assumes it is bound onto ped_countdown with the same MS_CYCLES.
*/
`default_nettype none
module ped_countdown_props #(
  parameter int MS_CYCLES = 50000
) (
  input wire logic         core_clk_i,
  input wire logic         rst_i,
  input wire logic         walk_lamp_i,
  input wire logic         halt_lamp_i,
  input wire logic         supply_good_i,
  input wire cd_pkg::seg_t seg_ones_o,
  input wire cd_pkg::seg_t seg_tens_o,
  input wire logic         display_on_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import cd_pkg::*;
  // ==========================================
  // helper counters
  localparam int LAMP_LIM = 1202 * MS_CYCLES + 8;
  localparam int PWR_LIM  = 1502 * MS_CYCLES + 8;
  // first step after a restart may come up to one tick early
  localparam int STEP_MIN = 999 * MS_CYCLES - 1;
  int  dark_cnt;
  int  halt_cnt;
  int  pwr_cnt;
  int  gap_cnt;
  wire digit_ok = seg_ones_o inside {7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
                                     7'h07, 7'h7F, 7'h6F};
  always_ff @(posedge core_clk_i) begin
    dark_cnt <= (walk_lamp_i | halt_lamp_i) ? 0 : dark_cnt + 1;
    halt_cnt <= halt_lamp_i ? halt_cnt + 1 : 0;
    pwr_cnt  <= supply_good_i ? 0 : pwr_cnt + 1;
    gap_cnt  <= $changed(seg_ones_o) ? 0 : gap_cnt + 1;
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  chk_reset_dark: assert property ($fell(rst_i) |-> !display_on_o &&
    seg_ones_o == 7'h00 && seg_tens_o == 7'h00)
    else $error("outputs not dark after reset");
  chk_blank_segs: assert property (!display_on_o |->
    seg_ones_o == 7'h00 && seg_tens_o == 7'h00)
    else $error("segments lit while display off");
  chk_tens_lead: assert property (display_on_o |-> seg_tens_o != 7'h3F)
    else $error("tens digit shows a leading zero");
  chk_digit_code: assert property (display_on_o |-> digit_ok)
    else $error("ones digit is not a decimal code");
  chk_walk_blank: assert property (walk_lamp_i [*8] |-> !display_on_o)
    else $error("count shown during walk");
  chk_dark_abort: assert property (dark_cnt >= LAMP_LIM |-> !display_on_o)
    else $error("count shown with both lamps dark");
  chk_steady_off: assert property (halt_cnt >= LAMP_LIM |-> !display_on_o)
    else $error("count shown during steady halt");
  chk_power_off: assert property (pwr_cnt >= PWR_LIM |-> !display_on_o)
    else $error("count shown after supply loss");
  chk_second_step: assert property (
    display_on_o && $past(display_on_o) && $changed(seg_ones_o) |-> gap_cnt >= STEP_MIN)
    else $error("count stepped faster than once a second");
  cover property ($rose(display_on_o));
  cover property (display_on_o && seg_ones_o == 7'h3F);
  cover property (dark_cnt == LAMP_LIM);
endmodule // ped_countdown_props
bind ped_countdown ped_countdown_props #(.MS_CYCLES(MS_CYCLES)) ped_countdown_props_inst (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .walk_lamp_i(walk_lamp_i),
  .halt_lamp_i(halt_lamp_i), .supply_good_i(supply_good_i), .seg_ones_o(seg_ones_o),
  .seg_tens_o(seg_tens_o), .display_on_o(display_on_o));
`default_nettype wire

// ### testbench/lamp_model.sv
/*
  Controller lamp outputs: walk, flashing halt, steady halt, dark.
  Assumes tasks are called right after a rising clock edge.
*/
`default_nettype none
module lamp_model #(
  parameter int MS_CYCLES = 2
) (
  input  wire logic core_clk_i,
  output var  logic walk_lamp_o,
  output var  logic halt_lamp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    walk_lamp_o = 1'b0;
    halt_lamp_o = 1'b0;
  end
  task automatic lamps(input logic w, input logic h, input int ms);
    walk_lamp_o <= w;
    halt_lamp_o <= h;
    repeat (ms * MS_CYCLES) @(posedge core_clk_i);
  endtask
  // half period kept well under the dark and steady thresholds
  task automatic flash(input int ms);
    for (int k = 0; k < ms; k += 250) lamps(1'b0, (k % 500) == 0, 250);
  endtask
endmodule // lamp_model
`default_nettype wire

// ### testbench/tb_top.sv
/*
  Self-checking bench for the countdown: learning, countdown, relearn,
  preemption, dark abort and supply loss. Assumes MS_CYCLES shortened to 2.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cd_pkg::*;
  // ==========================================
  // signals and instances
  localparam int   MS = 2;
  localparam int   LIMIT = 100000;
  localparam seg_t D0 = 7'h3F, D1 = 7'h06, D2 = 7'h5B, D3 = 7'h4F;
  logic core_clk_i = 1'b0;
  logic rst_i;
  logic supply_good_i;
  wire  walk_lamp;
  wire  halt_lamp;
  seg_t seg_ones;
  seg_t seg_tens;
  logic display_on;
  logic seen_on;
  int   fail_count;
  int   checks_done;
  int   cycles = 0;
  always #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (display_on === 1'b1) seen_on <= 1'b1;
  lamp_model #(.MS_CYCLES(MS)) lamp_model_inst (.core_clk_i(core_clk_i),
    .walk_lamp_o(walk_lamp), .halt_lamp_o(halt_lamp));
  ped_countdown #(.MS_CYCLES(MS)) ped_countdown_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .walk_lamp_i(walk_lamp), .halt_lamp_i(halt_lamp), .supply_good_i(supply_good_i),
    .seg_ones_o(seg_ones), .seg_tens_o(seg_tens), .display_on_o(display_on));
  // ==========================================
  // shared tasks
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_ms(input int ms);
    repeat (ms * MS) @(posedge core_clk_i);
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // values below ten keep the tens digit dark
  task automatic see(input logic e_on, input seg_t e_ones);
    check("display_on", {7'h00, e_on}, {7'h00, display_on});
    check("seg_ones", {1'b0, e_ones}, {1'b0, seg_ones});
    check("seg_tens", 8'h00, {1'b0, seg_tens});
  endtask
  task automatic run_flash(input int ms, input seg_t a, input seg_t b);
    fork
      lamp_model_inst.flash(ms);
      begin
        wait_ms(100);
        see(1'b1, a);
        wait_ms(1000);
        see(1'b1, b);
      end
    join
  endtask
  task automatic steady_check(input seg_t a);
    fork
      lamp_model_inst.lamps(1'b0, 1'b1, 1500);
      begin
        wait_ms(100);
        see(1'b1, a);
        wait_ms(1300);
        see(1'b0, 7'h00);
      end
    join
  endtask
  task automatic full_blank(input int clr);
    seen_on = 1'b0;
    lamp_model_inst.lamps(1'b1, 1'b0, 1000);
    lamp_model_inst.flash(clr);
    lamp_model_inst.lamps(1'b0, 1'b1, 1500);
    check("seen_on", 8'h00, {7'h00, seen_on});
  endtask
  // ==========================================
  // scenarios
  task automatic t_normal();
    lamp_model_inst.lamps(1'b1, 1'b0, 1000);
    run_flash(2000, D2, D1);
    steady_check(D0);
  endtask
  task automatic t_b2b();
    lamp_model_inst.lamps(1'b1, 1'b0, 1000);
    run_flash(2000, D2, D1);
    lamp_model_inst.lamps(1'b1, 1'b0, 1000);
    run_flash(2000, D2, D1);
    lamp_model_inst.lamps(1'b0, 1'b1, 1500);
  endtask
  task automatic t_preempt();
    lamp_model_inst.lamps(1'b1, 1'b0, 300);
    run_flash(1250, D2, D1);
    steady_check(D1);
    t_normal();
  endtask
  task automatic t_change();
    lamp_model_inst.lamps(1'b1, 1'b0, 1000);
    fork
      lamp_model_inst.flash(3000);
      begin
        wait_ms(100);
        see(1'b1, D2);
        wait_ms(2400);
        see(1'b1, D0);
        wait_ms(600);
        see(1'b0, 7'h00);
      end
    join
    lamp_model_inst.lamps(1'b0, 1'b1, 1500);
    full_blank(3000);
    lamp_model_inst.lamps(1'b1, 1'b0, 1000);
    fork
      lamp_model_inst.flash(500);
      begin
        wait_ms(100);
        see(1'b1, D3);
      end
    join
    lamp_model_inst.lamps(1'b0, 1'b0, 1500);
    see(1'b0, 7'h00);
  endtask
  task automatic t_power();
    supply_good_i <= 1'b0;
    wait_ms(1600);
    supply_good_i <= 1'b1;
    wait_ms(10);
    full_blank(2000);
    // count returns once the blank cycle has relearned
    lamp_model_inst.lamps(1'b1, 1'b0, 1000);
    fork
      lamp_model_inst.flash(500);
      begin
        wait_ms(100);
        see(1'b1, D2);
      end
    join
  endtask
  // ==========================================
  // main sequence and timeout
  initial begin
    rst_i = 1'b1;
    supply_good_i = 1'b1;
    seen_on = 1'b0;
    fail_count = 0;
    checks_done = 0;
    repeat (16) @(posedge core_clk_i);
    see(1'b0, 7'h00);
    rst_i <= 1'b0;
    full_blank(2000);
    t_normal();
    t_b2b();
    t_preempt();
    t_change();
    t_power();
    tally_and_finish();
  end
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      tally_and_finish();
    end
  end
endmodule // tb_top
`default_nettype wire
